// file: logic/drfa_pkg.sv
// Purpose: Shared constants for the divide, round and floating arithmetic datapath.
// Assumes: 36-bit words, sign at bit 0 in the word numbering, bit 35 least significant.
// Notes:   Word bit n (0 = sign) maps to vector index 35-n.
// Behaviour
// (RULE_01) Divide trial with no quotient carry sets divide check and ends the operation. The code sets it when the trial gives a Q carry.
// (RULE_02) Full-length divide loads the step count with octal 43 in execution cycle.
// (RULE_03) Divide-or-continue: divide check never sets the master stop trigger.
// (RULE_04) Variable divide takes its count from instruction bits 12 to 17.
// (RULE_05) Variable divide with zero count ends in execution cycle without shifting.
// (RULE_06) Count octal 43 equals full divide; larger counts spill quotient into accumulator.
// (RULE_07) Count octal 60 or more requests indirect cycle, ORing count into indirect word.
// (RULE_08) Variable divide-or-continue matches halt form but continues after divide check.
// (RULE_09) Round adds one at bit 35 when quotient bit 1 set; quotient unchanged.
// (RULE_10) Complement-magnitude inverts accumulator bits Q through 35 through the adder.
// (RULE_11) Floating word: exponent bits 1-8, fraction bits 9-35, sign on fraction.
// (RULE_12) Exponent coded with a bias of octal 200.
// (RULE_13) Normal means fraction bit 9 is one; all-zero word is a normal zero.
// (RULE_14) Normalizing instructions normalize the result; unnormalized ones leave it.
// (RULE_15) Float add aligns smaller-exponent operand right; bits leave bit 35 into quotient bit 9.
// (RULE_16) Unnormalized add sets quotient exponent 27 decimal below accumulator exponent.
// (RULE_17) Normalize shifts left until bit 9 set, reducing exponent per shift.
// (RULE_18) Float divide subtracts exponents then adds octal 200 back.
// (RULE_19) Float multiply adds exponents minus octal 200; high to accumulator, low to quotient.
// (RULE_20) Multiply and divide sign is plus when signs agree, minus otherwise.
// (RULE_21) Float add result takes sign of the larger-magnitude operand.
// (RULE_22) Float subtract inverts operand sign then proceeds as float add.
// (RULE_23) Five-step tally counter with extra cycles sequences float add, multiply, divide.
// (RULE_24) Tally counter returns to step one at start of each floating instruction.
package drfa_pkg;
  localparam int WORD_W = 36;
  localparam int FRAC_W = 27;
  localparam int EXP_W  = 8;
  localparam logic [5:0] FULL_DIV_COUNT = 6'h23;   // Octal 43
  localparam logic [5:0] IND_COUNT_MIN  = 6'h30;   // Octal 60
  localparam logic [7:0] EXP_BIAS       = 8'h80;   // Octal 200
  localparam logic [7:0] MQ_EXP_OFFSET  = 8'h1B;   // Decimal 27
  localparam int CNT_LSB = 18;                     // Word bits 12-17 at vector 23:18
  localparam logic [4:0] TALLY_FIRST    = 5'h01;
  typedef enum logic [3:0] {
    DRFA_NOP, DRFA_DIV_HALT, DRFA_DIV_CONT, DRFA_VDIV_HALT, DRFA_VDIV_CONT,
    DRFA_ROUND, DRFA_INVERT, DRFA_FADD, DRFA_UFADD, DRFA_FSUB, DRFA_UFSUB,
    DRFA_FMUL, DRFA_FDIV
  } drfa_op_e;
endpackage

// file: logic/drfa_tally.sv
// Purpose: Five-step tally counter selecting the floating extra-cycle phase.
// Assumes: One-hot steps; advance pulses come from the sequencer on mclk.
// Notes:   Holds at the fifth step if advanced beyond it.
`timescale 1ns/1ns
module drfa_tally (
  input  wire logic       mclk,    // Machine clock
  input  wire logic       reset,   // Synchronous reset
  input  wire logic       restart, // Start of a floating instruction
  input  wire logic       advance, // Current phase complete
  output logic      [4:0] step     // One-hot step
);
  logic [4:0] next_step;

  // Restart wins so each instruction opens in step one
  always_comb begin
    next_step = step;
    if (restart) begin
      next_step = drfa_pkg::TALLY_FIRST; // RULE_24
    end else if (advance && !step[4]) begin
      next_step = {step[3:0], 1'b0}; // RULE_23
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      step <= drfa_pkg::TALLY_FIRST;
    end else begin
      step <= next_step;
    end
  end

  AST_TALLY_RESTART: assert property (@(posedge mclk) disable iff (reset)
    restart |=> step == 5'h01) else $error("tally not at step one after restart"); // RULE_24
  AST_TALLY_ADV: assert property (@(posedge mclk) disable iff (reset)
    (advance && !restart && step == 5'h01) |=> step == 5'h02)
    else $error("tally did not advance"); // RULE_23
endmodule

// file: logic/drfa_adder.sv
// Purpose: Combinational adder with carry-in, used by all passes through the adder.
// Assumes: Operands already complemented where a subtraction is wanted.
// Notes:   Carry out of the top bit is the Q carry.
`timescale 1ns/1ns
module drfa_adder (
  input  wire logic [36:0] a,     // Q plus 36-bit magnitude field
  input  wire logic [36:0] b,     // Second operand
  input  wire logic        cin,   // Carry injected at bit 35
  output logic      [36:0] sum,   // Result
  output logic             cout   // Carry out of Q
);
  // One adder shared by round, complement and divide trials to save area
  always_comb begin
    {cout, sum} = {1'b0, a} + {1'b0, b} + {37'h0, cin};
  end
endmodule

// file: logic/drfa_core.sv
// Purpose: Divide, round, complement and floating arithmetic datapath.
// Assumes: Operand word arrives with start; sign held separately; one op at a time.
// Notes:   Accumulator carries Q and P overflow bits above its 35-bit magnitude.
`timescale 1ns/1ns
module drfa_core (
  input  wire logic        mclk,          // Machine clock, 100 MHz
  input  wire logic        reset,         // Synchronous reset
  input  wire logic        start,         // Begin operation, one-cycle pulse
  input  wire logic [3:0]  op,            // Operation code, drfa_op_e
  input  wire logic [35:0] instr,         // Instruction word
  input  wire logic [35:0] operand,       // Storage word to hold register
  input  wire logic        load_acc,      // Load accumulator from acc_in
  input  wire logic        load_mq,       // Load quotient register from mq_in
  input  wire logic [37:0] acc_in,        // S,Q,P,1..35 accumulator load
  input  wire logic [35:0] mq_in,         // Quotient register load
  input  wire logic        next_instr,    // Instruction cycle of next instruction
  output logic      [37:0] sum_register,  // Accumulator S,Q,P,1..35
  output logic      [35:0] multiplier_quotient_reg, // Quotient register
  output logic      [35:0] operand_hold_reg,        // Storage register
  output logic      [7:0]  step_count_reg,          // Step counter
  output logic             divide_check,  // Divide check trigger
  output logic             master_stop,   // Master stop trigger
  output logic             busy,          // Operation in progress
  output logic             end_op,        // End of operation pulse
  output logic             ind_req,       // Indirect cycle request pulse
  output logic      [5:0]  ind_or_bits,   // Bits ORed into indirect word 12-17
  output logic      [4:0]  tally_step     // Floating phase
);
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_LOOP, ST_ALIGN, ST_COMB, ST_NORM, ST_FIN}
    drfa_st_e;
  drfa_st_e state, next_state;
  drfa_pkg::drfa_op_e cur_op, next_cur_op;
  logic [37:0] next_acc;
  logic [35:0] next_mq, next_sr;
  logic [7:0]  next_sc;
  logic        next_dchk, next_mstop, next_end, next_ind;
  logic [5:0]  next_ind_bits;
  logic        dchk_halts, next_dchk_halts;
  logic [36:0] add_a, add_b, add_s;
  logic        add_cin, add_cout;
  logic        restart, advance;
  logic [5:0]  count;
  logic [8:0]  exp_calc;
  logic        is_div, is_cont, is_fadd, is_norm;

  assign count = instr[drfa_pkg::CNT_LSB +: 6]; // RULE_04
  assign is_div = cur_op inside {drfa_pkg::DRFA_DIV_HALT, drfa_pkg::DRFA_DIV_CONT,
                                 drfa_pkg::DRFA_VDIV_HALT, drfa_pkg::DRFA_VDIV_CONT};
  assign is_cont = (op == drfa_pkg::DRFA_DIV_CONT) || (op == drfa_pkg::DRFA_VDIV_CONT);
  assign is_fadd = cur_op inside {drfa_pkg::DRFA_FADD, drfa_pkg::DRFA_UFADD,
                                  drfa_pkg::DRFA_FSUB, drfa_pkg::DRFA_UFSUB};
  assign is_norm = cur_op inside {drfa_pkg::DRFA_FADD, drfa_pkg::DRFA_FSUB,
                                  drfa_pkg::DRFA_FMUL, drfa_pkg::DRFA_FDIV}; // RULE_14
  assign busy = (state != ST_IDLE);
  assign restart = start && (op inside {drfa_pkg::DRFA_FADD, drfa_pkg::DRFA_UFADD,
    drfa_pkg::DRFA_FSUB, drfa_pkg::DRFA_UFSUB, drfa_pkg::DRFA_FMUL, drfa_pkg::DRFA_FDIV});

  drfa_adder u_adder (
    .a    (add_a),
    .b    (add_b),
    .cin  (add_cin),
    .sum  (add_s),
    .cout (add_cout)
  );

  drfa_tally u_tally (
    .mclk    (mclk),
    .reset   (reset),
    .restart (restart),
    .advance (advance),
    .step    (tally_step)
  );

  // Adder input select: carry from quotient bit 1 for round, inverted accumulator for complement, complement trial for divide
  always_comb begin
    add_a   = sum_register[36:0];
    add_b   = 37'h0;
    add_cin = 1'b0;
    if (state == ST_EXEC && cur_op == drfa_pkg::DRFA_ROUND) begin
      add_cin = multiplier_quotient_reg[34]; // RULE_09
    end else if (state == ST_EXEC && cur_op == drfa_pkg::DRFA_INVERT) begin
      add_a = ~sum_register[36:0]; // RULE_10
    end else if (is_div) begin
      add_a   = {2'b00, sum_register[34:0]};
      add_b   = {2'b11, ~operand_hold_reg[34:0]};
      add_cin = 1'b1;
    end
  end

  // Main sequencer: computes every datapath next value
  always_comb begin
    next_state      = state;
    next_cur_op     = cur_op;
    next_acc        = sum_register;
    next_mq         = multiplier_quotient_reg;
    next_sr         = operand_hold_reg;
    next_sc         = step_count_reg;
    next_dchk       = divide_check;
    next_mstop      = master_stop;
    next_dchk_halts = dchk_halts;
    next_end        = 1'b0;
    next_ind        = 1'b0;
    next_ind_bits   = ind_or_bits;
    advance         = 1'b0;
    exp_calc        = 9'h0;
    if (load_acc) next_acc = acc_in;
    if (load_mq) next_mq = mq_in;
    // Checked stop only when the halting form raised the check
    if (next_instr && divide_check && dchk_halts) begin
      next_mstop = 1'b1; // RULE_03 RULE_08
    end
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_cur_op = drfa_pkg::drfa_op_e'(op);
          next_sr     = operand;
          next_state  = ST_EXEC;
          if (op == drfa_pkg::DRFA_FSUB || op == drfa_pkg::DRFA_UFSUB) begin
            next_sr[35] = ~operand[35]; // RULE_22
          end
          if (op inside {drfa_pkg::DRFA_DIV_HALT, drfa_pkg::DRFA_DIV_CONT,
                         drfa_pkg::DRFA_VDIV_HALT, drfa_pkg::DRFA_VDIV_CONT}) begin
            next_dchk       = 1'b0;
            next_dchk_halts = !is_cont; // RULE_03 RULE_08
            if (op == drfa_pkg::DRFA_DIV_HALT || op == drfa_pkg::DRFA_DIV_CONT) begin
              next_sc = {2'b00, drfa_pkg::FULL_DIV_COUNT}; // RULE_02
            end else begin
              next_sc = {2'b00, count}; // RULE_04 RULE_06
              if (count >= drfa_pkg::IND_COUNT_MIN) begin
                next_ind      = 1'b1; // RULE_07
                next_ind_bits = count;
              end
            end
          end
        end
      end
      ST_EXEC: begin
        if (cur_op == drfa_pkg::DRFA_ROUND || cur_op == drfa_pkg::DRFA_INVERT) begin
          next_acc   = {sum_register[37], add_s}; // RULE_09 RULE_10
          next_end   = 1'b1;
          next_state = ST_IDLE;
        end else if (is_div) begin
          // Trial is dividend high minus divisor: a carry means the quotient would overflow
          if (add_cout) begin
            next_dchk  = 1'b1; // RULE_01
            next_end   = 1'b1;
            next_state = ST_IDLE;
          end else if (step_count_reg == 8'h00) begin
            next_end   = 1'b1; // RULE_05
            next_state = ST_IDLE;
          end else begin
            // Shift the dividend left and take the quotient sign
            next_acc = {sum_register[37:35], sum_register[33:0], multiplier_quotient_reg[34]};
            next_mq  = {operand_hold_reg[35] ^ sum_register[37],
                        multiplier_quotient_reg[33:0], 1'b0}; // RULE_20
            next_sc  = step_count_reg - 8'h01;
            next_state = ST_LOOP;
          end
        end else begin
          next_state = is_fadd ? ST_ALIGN : ST_COMB;
          if (is_fadd && operand_hold_reg[34:27] < sum_register[34:27]) begin // RULE_11
            // Smaller exponent goes to the accumulator for shifting
            next_acc = {operand_hold_reg[35], 2'b00, operand_hold_reg[34:0]}; // RULE_15
            next_sr  = {sum_register[37], sum_register[34:0]};
          end
          if (is_fadd) begin
            next_sc = {2'b00, 6'h0} + (is_fadd && operand_hold_reg[34:27] < sum_register[34:27]
              ? sum_register[34:27] - operand_hold_reg[34:27]
              : operand_hold_reg[34:27] - sum_register[34:27]);
            next_mq = 36'h0;
          end
          advance = 1'b1;
        end
      end
      ST_LOOP: begin
        // Successful reduction leaves a one in quotient bit 35; large counts spill upward
        if (add_cout) begin
          next_acc[34:0] = add_s[34:0];
          next_mq[0]     = 1'b1;
        end
        if (step_count_reg == 8'h00) begin
          next_end   = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_acc = {sum_register[37:35], (add_cout ? add_s[33:0] : sum_register[33:0]),
                      multiplier_quotient_reg[34]}; // RULE_06
          next_mq  = {multiplier_quotient_reg[35], multiplier_quotient_reg[33:0], add_cout};
          next_sc  = step_count_reg - 8'h01;
        end
      end
      ST_ALIGN: begin
        // Right shift one place per cycle, counts above 63 clear the fraction at once; accumulator bit 35 falls into quotient bit 9
        if (step_count_reg == 8'h00) begin
          next_state = ST_COMB;
          advance    = 1'b1;
        end else if (step_count_reg > 8'h3F) begin
          next_acc[26:0] = 27'h0;
          next_sc        = 8'h00;
        end else begin
          next_acc[26:0] = {1'b0, sum_register[26:1]};
          next_mq[26:0]  = {sum_register[0], multiplier_quotient_reg[26:1]}; // RULE_15
          next_sc        = step_count_reg - 8'h01;
        end
      end
      ST_COMB: begin
        advance = 1'b1;
        if (is_fadd) begin
          // Signed fraction add; larger magnitude sets the sign
          next_acc[34:27] = operand_hold_reg[34:27];
          if (sum_register[37] == operand_hold_reg[35]) begin
            {next_acc[35], next_acc[26:0]} = {1'b0, sum_register[26:0]}
              + {1'b0, operand_hold_reg[26:0]};
            if (next_acc[35]) begin
              next_mq[26:0]   = {sum_register[0] ^ operand_hold_reg[0],
                                 multiplier_quotient_reg[26:1]};
              next_acc[26:0]  = {1'b1, next_acc[26:1]};
              next_acc[34:27] = operand_hold_reg[34:27] + 8'h01;
              next_acc[35]    = 1'b0;
            end
          end else if (sum_register[26:0] > operand_hold_reg[26:0]) begin
            next_acc[26:0] = sum_register[26:0] - operand_hold_reg[26:0];
          end else begin
            next_acc[26:0] = operand_hold_reg[26:0] - sum_register[26:0];
            next_acc[37]   = operand_hold_reg[35]; // RULE_21
          end
        end else if (cur_op == drfa_pkg::DRFA_FMUL) begin
          {next_acc[26:0], next_mq[26:0]} = multiplier_quotient_reg[26:0]
                                            * operand_hold_reg[26:0]; // RULE_19
          exp_calc = {1'b0, multiplier_quotient_reg[34:27]} + {1'b0, operand_hold_reg[34:27]}
                     - {1'b0, drfa_pkg::EXP_BIAS}; // RULE_19 RULE_12
          next_acc[34:27] = exp_calc[7:0];
          next_acc[37]    = multiplier_quotient_reg[35] ^ operand_hold_reg[35]; // RULE_20
        end else if (operand_hold_reg[26:0] != 27'h0) begin
          next_acc[26:0] = 27'(({sum_register[26:0], 27'h0}) / {27'h0, operand_hold_reg[26:0]});
          exp_calc = {1'b0, sum_register[34:27]} - {1'b0, operand_hold_reg[34:27]}
                     + {1'b0, drfa_pkg::EXP_BIAS}; // RULE_18
          next_acc[34:27] = exp_calc[7:0];
          next_acc[37]    = sum_register[37] ^ operand_hold_reg[35]; // RULE_20
        end else begin
          next_dchk = 1'b1;
        end
        next_state = ST_NORM;
      end
      ST_NORM: begin
        // Normalizing ops only: zero fraction becomes a normal zero; else shift until bit 9 set
        if (!is_norm || sum_register[26]) begin
          next_state = ST_FIN; // RULE_14
          advance    = 1'b1;
        end else if (sum_register[26:0] == 27'h0) begin
          next_acc[34:0] = 35'h0; // RULE_13
          next_state     = ST_FIN;
          advance        = 1'b1;
        end else begin
          next_acc[26:0]  = {sum_register[25:0], multiplier_quotient_reg[26]}; // RULE_17
          next_mq[26:0]   = {multiplier_quotient_reg[25:0], 1'b0};
          next_acc[34:27] = sum_register[34:27] - 8'h01; // RULE_17
        end
      end
      ST_FIN: begin
        // Add forms only: low part carries the sign and sits 27 below in exponent
        if (is_fadd) begin
          next_mq[35]    = sum_register[37];
          next_mq[34:27] = sum_register[34:27] - drfa_pkg::MQ_EXP_OFFSET; // RULE_16
        end
        next_end   = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state                   <= ST_IDLE;
      cur_op                  <= drfa_pkg::DRFA_NOP;
      sum_register            <= 38'h0;
      multiplier_quotient_reg <= 36'h0;
      operand_hold_reg        <= 36'h0;
      step_count_reg          <= 8'h00;
      divide_check            <= 1'b0;
      master_stop             <= 1'b0;
      dchk_halts              <= 1'b0;
      end_op                  <= 1'b0;
      ind_req                 <= 1'b0;
      ind_or_bits             <= 6'h00;
    end else begin
      state                   <= next_state;
      cur_op                  <= next_cur_op;
      sum_register            <= next_acc;
      multiplier_quotient_reg <= next_mq;
      operand_hold_reg        <= next_sr;
      step_count_reg          <= next_sc;
      divide_check            <= next_dchk;
      master_stop             <= next_mstop;
      dchk_halts              <= next_dchk_halts;
      end_op                  <= next_end;
      ind_req                 <= next_ind;
      ind_or_bits             <= next_ind_bits;
    end
  end

  AST_DCHK_SET: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_EXEC && is_div && add_cout) |=> divide_check && end_op)
    else $error("no divide check on failed trial"); // RULE_01
  AST_FULL_COUNT: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_IDLE && start && op == 4'(drfa_pkg::DRFA_DIV_HALT))
    |=> step_count_reg == 8'h23) else $error("full divide count wrong"); // RULE_02
  AST_NO_STOP_CONT: assert property (@(posedge mclk) disable iff (reset)
    (!dchk_halts && !master_stop) |=> !master_stop)
    else $error("continue form stopped machine"); // RULE_03
  AST_ZERO_COUNT: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_EXEC && is_div && !add_cout && step_count_reg == 8'h00)
    |=> end_op && $stable(multiplier_quotient_reg)) else $error("zero count shifted"); // RULE_05
  AST_IND: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_IDLE && start && op == 4'(drfa_pkg::DRFA_VDIV_HALT) && count >= 6'h30)
    |=> ind_req && ind_or_bits == $past(count)) else $error("no indirect request"); // RULE_07
  AST_ROUND: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_EXEC && cur_op == drfa_pkg::DRFA_ROUND && !load_acc && !load_mq)
    |=> sum_register[36:0] == $past(sum_register[36:0]) + 37'($past(multiplier_quotient_reg[34]))
    && $stable(multiplier_quotient_reg)) else $error("round result wrong"); // RULE_09
  AST_INVERT: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_EXEC && cur_op == drfa_pkg::DRFA_INVERT && !load_acc)
    |=> sum_register[36:0] == ~$past(sum_register[36:0])) else $error("complement wrong"); // RULE_10
  AST_MQ_EXP: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_FIN && is_fadd && !load_mq)
    |=> multiplier_quotient_reg[34:27] == $past(sum_register[34:27]) - 8'h1B)
    else $error("low part exponent wrong"); // RULE_16
  AST_NORM_DONE: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_NORM && is_norm) ##1 (state == ST_FIN && !load_acc)
    |-> sum_register[26] || sum_register[34:0] == 35'h0) else $error("not normal"); // RULE_13
endmodule

// file: bench/drfa_seq_model.sv
// Purpose: Sequencer partner; opens the next instruction cycle after each end of operation.
// Assumes: One instruction in flight at a time.
// Notes:   A slow sequencer waits four cycles, so late stop logic is exercised too.
`timescale 1ns/1ns
module drfa_seq_model (
  input  wire logic mclk,      // Machine clock
  input  wire logic reset,     // Synchronous reset
  input  wire logic end_op,    // End of operation
  input  wire logic slow,      // Stretch the gap
  output logic      next_instr // Next instruction cycle
);
  logic [2:0] gap;
  // Count down from end of operation to the next instruction cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      gap <= 3'h0;
      next_instr <= 1'b0;
    end else begin
      next_instr <= (gap == 3'h1);
      if (end_op) begin
        gap <= slow ? 3'h4 : 3'h1;
      end else if (gap != 3'h0) begin
        gap <= gap - 3'h1;
      end
    end
  end
endmodule

// file: bench/drfa_core_tb.sv
// Purpose: Self-checking bench for the divide, round and floating datapath.
// Assumes: Inputs change on the falling edge; results are checked at end_op.
// Notes:   Expected words are built here from the word layout, never read back.
`timescale 1ns/1ns
module drfa_core_tb;
  logic        mclk, reset, start, load_acc, load_mq, next_instr, slow, divide_check;
  logic        master_stop, busy, end_op, ind_req;
  logic [3:0]  op;
  logic [35:0] instr, operand, mq_in, multiplier_quotient_reg, operand_hold_reg, q;
  logic [37:0] acc_in, sum_register, a;
  logic [7:0]  step_count_reg;
  logic [5:0]  ind_or_bits, ind_exp;
  logic [4:0]  tally_step;
  logic [74:0] exp_q[$], msk_q[$];
  int          fails, cmp_count, seed, i, ind_cnt;
  localparam logic [74:0] MS = {37'h0, {38{1'b1}}};
  localparam logic [74:0] QM = {1'b0, {36{1'b1}}, 38'h0};
  drfa_core dut (.mclk(mclk), .reset(reset), .start(start), .op(op), .instr(instr),
    .operand(operand), .load_acc(load_acc), .load_mq(load_mq), .acc_in(acc_in),
    .mq_in(mq_in), .next_instr(next_instr), .sum_register(sum_register),
    .multiplier_quotient_reg(multiplier_quotient_reg), .operand_hold_reg(operand_hold_reg),
    .step_count_reg(step_count_reg), .divide_check(divide_check), .master_stop(master_stop),
    .busy(busy), .end_op(end_op), .ind_req(ind_req), .ind_or_bits(ind_or_bits),
    .tally_step(tally_step));
  drfa_seq_model seq (.mclk(mclk), .reset(reset), .end_op(end_op), .slow(slow),
    .next_instr(next_instr));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [74:0] e, m, s);
    cmp_count++;
    if ((s & m) !== (e & m)) begin
      fails++;
      $display("[ERR] result exp %h seen %h", e & m, s & m);
    end
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic ld(input logic [37:0] av, input logic [35:0] qv);
    @(negedge mclk);
    {load_acc, load_mq, acc_in, mq_in} = {2'b11, av, qv};
    @(negedge mclk);
    {load_acc, load_mq} = 2'b00;
  endtask
  // Queue the expectation, pulse start, then wait a bounded time for the end
  task automatic run(input logic [3:0] o, input logic [5:0] c, input logic [35:0] w,
                     input logic [74:0] e, m);
    int n;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge mclk);
    {start, op, instr, operand} = {1'b1, o, 12'h0, c, 18'h0, w};
    @(negedge mclk);
    start = 1'b0;
    for (n = 0; end_op !== 1'b1; n++) begin
      if (n > 300) begin
        fails++;
        print_verdict();
      end
      @(negedge mclk);
    end
    @(negedge mclk);
    $display("Test op %0d done", o);
  endtask
  // Watcher: the oldest note is compared whenever a result appears
  always @(negedge mclk) begin
    if (end_op === 1'b1) chk(exp_q.pop_front(), msk_q.pop_front(),
      {divide_check, multiplier_quotient_reg, sum_register});
    if (ind_req === 1'b1) begin
      ind_cnt++;
      chk({69'h0, ind_exp}, 75'h3f, {69'h0, ind_or_bits});
    end
  end
  initial begin
    {seed, fails, cmp_count, ind_cnt, start, op, instr, operand} = {32'd87, 96'h0, 77'h0};
    {load_acc, load_mq, acc_in, mq_in, slow, ind_exp, reset} = {83'h0, 1'b1};
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    chk(75'h1, 75'h1f, {70'h0, tally_step});
    for (i = 0; i < 8; i++) begin
      a = {6'($random(seed)), 32'($random(seed))};
      q = {4'($random(seed)), 32'($random(seed))};
      q[34] = i[0];
      ld(a, q);
      a = {a[37], a[36:0] + 37'(q[34])};
      run(drfa_pkg::DRFA_ROUND, 6'h0, 36'h0, {1'b0, q, a}, MS | QM);
      run(drfa_pkg::DRFA_INVERT, 6'h0, 36'h0, {1'b0, q, a[37], ~a[36:0]}, MS);
    end
    for (i = 1; i < 5; i++) begin
      reset = 1'b1;
      @(negedge mclk);
      {reset, slow} = {1'b0, i[0]};
      ld(38'h4_0000_0000, 36'h0);
      run(4'(i), 6'h05, 36'h0100, {1'b1, 74'h0}, {1'b1, 74'h0});
      repeat (10) @(negedge mclk);
      chk(75'(i % 2), 75'h1, 75'(master_stop));
      chk(75'(i < 3 ? 9'h023 : 9'h005), 75'h1ff, 75'({busy, step_count_reg}));
    end
    ld(38'h1, 36'h1234_5678);
    run(drfa_pkg::DRFA_VDIV_HALT, 6'h0, 36'h10_0000, {1'b0, 36'h1234_5678, 38'h0},
        QM | {1'b1, 74'h0});
    for (i = 0; i < 2; i++) begin
      ind_exp = i[0] ? 6'h3f : 6'h30;
      ld(38'h1, 36'h0);
      run(i[0] ? drfa_pkg::DRFA_VDIV_CONT : drfa_pkg::DRFA_VDIV_HALT, ind_exp, 36'h10_0000,
          75'h0, 75'h0);
    end
    chk(75'h2, 75'h3, 75'(ind_cnt));
    ld({3'h0, 8'h81, 27'h100_0000}, 36'h0);
    run(drfa_pkg::DRFA_UFADD, 6'h0, {1'b0, 8'h81, 27'h100_0000},
        {37'h0, 3'h0, 8'h81, 27'h200_0000}, MS);
    ld({3'h0, 8'h81, 27'h100_0000}, 36'h0);
    run(drfa_pkg::DRFA_FADD, 6'h0, {1'b0, 8'h81, 27'h100_0000},
        {37'h0, 3'h0, 8'h80, 27'h400_0000}, MS);
    chk(75'h10, 75'h1f, {70'h0, tally_step});
    ld({3'h0, 8'h81, 27'h100_0000}, 36'h0);
    run(drfa_pkg::DRFA_UFSUB, 6'h0, {1'b0, 8'h81, 27'h300_0000},
        {37'h0, 3'h4, 8'h81, 27'h200_0000}, MS);
    ld(38'h0, {1'b1, 8'h80, 27'h400_0000});
    run(drfa_pkg::DRFA_FMUL, 6'h0, {1'b0, 8'h80, 27'h400_0000},
        {37'h0, 3'h4, 8'h7f, 27'h400_0000}, MS & ~(75'h3 << 35));
    ld({3'h0, 8'h81, 27'h200_0000}, 36'h0);
    run(drfa_pkg::DRFA_FDIV, 6'h0, {1'b1, 8'h80, 27'h400_0000},
        {37'h0, 3'h4, 8'h81, 27'h400_0000}, MS);
    print_verdict();
  end
endmodule
